// ==== common/ses_pkg.sv ====
// package: constants and types of the servo external signal selector
package ses_pkg;

    // ****************************************
    // signal slots and source codes
    // ****************************************
    localparam int SIG_N = 4;
    localparam int SIG_UPPER = 0;
    localparam int SIG_LOWER = 1;
    localparam int SIG_STOP = 2;
    localparam int SIG_DOG = 3;
    localparam int SYNC_W = 39;

    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_LIMMOD = 3'h1,
        SRC_AMP = 3'h2,
        SRC_DIN = 3'h3,
        SRC_BITDEV = 3'h4
    } ses_src_t;

    typedef enum logic [2:0] {
        DEV_IN = 3'h0,
        DEV_OUT = 3'h1,
        DEV_INT = 3'h2,
        DEV_LINK = 3'h3,
        DEV_ANN = 3'h4,
        DEV_SPEC = 3'h5,
        DEV_SHR = 3'h6
    } ses_dcls_t;

    typedef struct packed {
        logic [12:0] dnum;
        ses_dcls_t dcls;
        logic [3:0] chan;
        logic [2:0] modn;
        logic pol;
        ses_src_t typ;
    } ses_cfg_t;

    typedef struct packed {
        ses_dcls_t dcls;
        logic [12:0] dnum;
    } ses_dev_t;

    // ****************************************
    // register map and reset values
    // ****************************************
    localparam logic [7:0] ADDR_CFG_UPPER = 8'h00;
    localparam logic [7:0] ADDR_CFG_DOG = 8'h0c;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_DET = 8'h14;
    localparam logic [7:0] ADDR_ISTAT = 8'h18;
    localparam logic [7:0] ADDR_IMASK = 8'h1c;
    localparam int CTRL_MODE_BIT = 16;
    localparam ses_cfg_t CFG_RST = ses_cfg_t'(27'h0);
    localparam logic [12:0] DIN_BASE_RST = 13'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [3:0] DIN_HOLE_LO = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // bit device number limits
    // ****************************************
    localparam logic [12:0] DEV_HEX_MAX = 13'h1fff;
    localparam logic [12:0] DEV_INT_MAX = 13'h1fff;
    localparam logic [12:0] DEV_ANN_MAX = 13'h07ff;
    localparam logic [12:0] DEV_SPEC_MAX = 13'h07cf;
    localparam logic [12:0] DEV_SHR_MAX = 13'h00ff;

    function automatic logic ses_dev_ok(input ses_cfg_t c);
        logic ok;
        ok = 1'b0;
        case (c.dcls)
            DEV_IN, DEV_OUT, DEV_LINK: ok = (c.dnum <= DEV_HEX_MAX);
            DEV_INT: ok = (c.dnum <= DEV_INT_MAX);
            DEV_ANN: ok = (c.dnum <= DEV_ANN_MAX);
            DEV_SPEC: ok = (c.dnum <= DEV_SPEC_MAX);
            DEV_SHR: ok = (c.dnum <= DEV_SHR_MAX);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // byte-lane merge of a register write
    function automatic logic [31:0] ses_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// ==== dv/ses_field.sv ====
// partner model: field bit devices answering the selected device numbers
`timescale 1ns/1ps
`default_nettype none
module ses_field
    import ses_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [63:0] img_i,
    input wire ses_dev_t [3:0] sel_i,
    output logic [3:0] val_o
);
    // ********
    // device lookup, one cycle late
    // ********
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            val_o <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                val_o[i] <= img_i[sel_i[i].dnum[5:0]];
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// testbench: selector model, register bus master and field stimulus
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("mismatch t=%0t %s", $time, m); end end
module tb_top
    import ses_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, lim = 32'h0, seed = 32'hbcd0a376;
    logic [3:0] wstrb = 4'hf, din = 4'h0;
    logic [2:0] amp = 3'h0;
    logic [63:0] img = 64'h0;
    logic fwd = 1'b0, rev = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, fok, rok, stp, hom, chg;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, tv, wv, pv;
    logic [3:0] devv, det, ev;
    ses_dev_t [3:0] dsel;
    ses_cfg_t cm [4];
    ses_cfg_t c;
    ses_dcls_t tc [4] = '{DEV_SPEC, DEV_SPEC, DEV_ANN, DEV_INT};
    logic [12:0] tn [4] = '{13'h7d0, 13'h7cf, 13'h800, 13'h1fff};
    logic [3:0] tok = 4'b1010;
    int fails = 0, cmp_count = 0, k, ns, nh, nc;

    always #50 clk = ~clk;

    ses_top dut (.core_clk_i(clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .lim_mod_i(lim), .amp_in_i(amp), .dig_in_i(din),
        .dev_val_i(devv), .fwd_req_i(fwd), .rev_req_i(rev), .dev_sel_o(dsel), .det_o(det),
        .fwd_ok_o(fok), .rev_ok_o(rok), .stop_cmd_o(stp), .home_trig_o(hom),
        .chg_trig_o(chg), .irq_o(irq));
    ses_field field (.core_clk_i(clk), .rst_b_i(rst_b), .img_i(img), .sel_i(dsel),
        .val_o(devv));

    // ********
    // helpers
    // ********
    task automatic finish_test();
        $display("counts: compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        if (n == 100)
        begin
            fails++;
            finish_test();
        end
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        if (n == 100)
        begin
            fails++;
            finish_test();
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // expected detection of signal k under configuration c
    function automatic logic exp_det(input int k, input ses_cfg_t c);
        logic raw;
        logic v;
        logic ok;
        int m;
        int ch;
        raw = 1'b0;
        v = 1'b1;
        m = int'(c.modn);
        ch = int'(c.chan);
        ok = m >= 1 && m <= 4;
        case (c.typ)
            SRC_LIMMOD:
            begin
                v = ok && ch >= 1 && ch <= 8;
                raw = v ? lim[(m - 1) * 8 + ch - 1] : 1'b0;
            end
            SRC_AMP:
            begin
                v = k != SIG_STOP;
                raw = amp[(k == SIG_DOG) ? 2 : k];
            end
            SRC_DIN:
            begin
                v = ok && k == SIG_DOG;
                raw = ok ? din[m - 1] : 1'b0;
            end
            SRC_BITDEV: raw = img[c.dnum[5:0]] &&
                !(c.dcls == DEV_IN && c.dnum >= 13'h14 && c.dnum <= 13'h1f);
            default: v = 1'b0;
        endcase
        return v && (raw ^ c.pol);
    endfunction

    // ********
    // scenarios
    // ********
    initial
    begin
        for (int j = 0; j < 4; j++)
            cm[j] = CFG_RST;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        for (int a = 0; a < 9; a++)
        begin
            rd(8'(a * 4), tv, rs);
            `CHK(tv, 32'h0, "reset value")
            `CHK(rs, (a == 8) ? RESP_SLVERR : RESP_OKAY, "read resp")
        end
        $display("test reset done");
        wr(ADDR_CTRL, 32'h10, rs);
        for (int it = 0; it < 60; it++)
        begin
            k = xs() % 4;
            c = ses_cfg_t'(27'(xs()));
            c.typ = ses_src_t'(3'(xs() % 5));
            c.dcls = ses_dcls_t'(3'(xs() % 7));
            c.dnum = 13'(xs() % 64);
            wr(ADDR_CFG_UPPER + 8'(k * 4), 32'(c), rs);
            `CHK(rs, RESP_OKAY, "cfg write")
            cm[k] = c;
            lim <= xs();
            amp <= 3'(xs());
            din <= 4'(xs());
            img <= {xs(), xs()};
            fwd <= 1'(xs());
            rev <= 1'(xs());
            repeat (10) @(posedge clk);
            for (int j = 0; j < 4; j++)
                ev[j] = exp_det(j, cm[j]);
            `CHK(det, ev, "det")
            `CHK(fok, fwd & ~ev[0], "fwd")
            `CHK(rok, rev & ~ev[1], "rev")
            rd(ADDR_DET, tv, rs);
            `CHK(tv[3:0], ev, "det reg")
        end
        $display("test select done");
        pv = 32'h0;
        wr(ADDR_CFG_UPPER, pv, rs);
        for (int t = 0; t < 4; t++)
        begin
            wv = 32'h4 | (32'(tc[t]) << 11) | (32'(tn[t]) << 14);
            wr(ADDR_CFG_UPPER, wv, rs);
            `CHK(rs, tok[t] ? RESP_OKAY : RESP_SLVERR, "dev range")
            if (tok[t])
                pv = wv;
            rd(ADDR_CFG_UPPER, tv, rs);
            `CHK(tv, pv, "dev keep")
        end
        // built-in input block: offset 3 is live, offset 5 reads zero
        img <= '1;
        for (int h = 0; h < 3; h++)
        begin
            c = ses_cfg_t'(27'h4);
            c.dnum = (h == 0) ? 13'h13 : 13'h15;
            c.pol = (h == 2);
            wr(ADDR_CFG_DOG, 32'(c), rs);
            repeat (6) @(posedge clk);
            `CHK(det[SIG_DOG], 1'(h != 1), "hole")
        end
        $display("test device done");
        for (int md = 0; md < 2; md++)
        begin
            lim <= 32'h0;
            for (int j = 0; j < 4; j++)
                wr(ADDR_CFG_UPPER + 8'(j * 4), 32'h0, rs);
            wr(ADDR_CTRL, 32'h10 | (32'(md) << CTRL_MODE_BIT), rs);
            wr(ADDR_IMASK, 32'h4, rs);
            wr(ADDR_CFG_UPPER + 8'h8, 32'h91, rs);
            wr(ADDR_CFG_DOG, 32'h111, rs);
            repeat (8) @(posedge clk);
            rd(ADDR_ISTAT, tv, rs);
            ns = 0;
            nh = 0;
            nc = 0;
            lim <= 32'h3;
            repeat (14)
            begin
                @(posedge clk);
                ns += int'(stp);
                nh += int'(hom);
                nc += int'(chg);
            end
            `CHK(ns, 1, "stop pulse")
            `CHK(nh, 1 - md, "home pulse")
            `CHK(nc, md, "switch pulse")
            `CHK(irq, 1'b1, "irq set")
            rd(ADDR_ISTAT, tv, rs);
            `CHK(tv[3:0], 4'hc, "status")
            `CHK(irq, 1'b0, "irq clear")
            lim <= 32'h1;
            repeat (8) @(posedge clk);
            lim <= 32'h3;
            repeat (8) @(posedge clk);
            `CHK(irq, 1'b0, "irq masked")
            wr(ADDR_IMASK, 32'h8, rs);
            @(posedge clk);
            `CHK(irq, 1'b1, "irq unmasked")
            rd(ADDR_ISTAT, tv, rs);
            `CHK(tv[3:0], 4'h8, "status dog")
        end
        $display("test events done");
        finish_test();
    end
endmodule
`default_nettype wire

// ==== verilog/ses_sel.sv ====
// module: source selection and polarity for one external signal
`timescale 1ns/1ps
`default_nettype none
module ses_sel
    import ses_pkg::*;
#(
    parameter int KIND = SIG_UPPER
)
(
    input wire ses_cfg_t cfg_i,
    input wire logic [31:0] lim_i,
    input wire logic [2:0] amp_i,
    input wire logic [3:0] din_i,
    input wire logic dev_i,
    output logic det_o
);
    wire [1:0] mod_idx = 2'(cfg_i.modn - 3'h1);
    wire [2:0] ch_idx = 3'(cfg_i.chan - 4'h1);
    wire mod_ok = (cfg_i.modn >= 3'h1) && (cfg_i.modn <= 3'h4);
    wire ch_ok = (cfg_i.chan >= 4'h1) && (cfg_i.chan <= 4'h8);
    wire lim_raw = lim_i[{mod_idx, ch_idx}];
    wire amp_raw = (KIND == SIG_UPPER) ? amp_i[0] : (KIND == SIG_LOWER) ? amp_i[1] : amp_i[2];
    wire din_raw = din_i[mod_idx];

    // ****************************************
    // code validity per signal kind
    // ****************************************
    wire ok_lim = (cfg_i.typ == SRC_LIMMOD) && mod_ok && ch_ok;
    wire ok_amp = (cfg_i.typ == SRC_AMP) && (KIND != SIG_STOP);
    wire ok_din = (cfg_i.typ == SRC_DIN) && (KIND == SIG_DOG) && mod_ok;
    wire ok_dev = (cfg_i.typ == SRC_BITDEV) && ses_dev_ok(cfg_i);
    wire valid = ok_lim | ok_amp | ok_din | ok_dev;
    wire raw = ok_lim ? lim_raw : ok_amp ? amp_raw : ok_din ? din_raw : dev_i;

    // normal close inverts the sense; an unused code stays quiet
    assign det_o = valid & (raw ^ cfg_i.pol);
endmodule
`default_nettype wire

// ==== verilog/ses_sync.sv ====
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ses_sync
    import ses_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [SYNC_W-1:0] d_i,
    output logic [SYNC_W-1:0] q_o
);
    logic [SYNC_W-1:0] s1_r;
    logic [SYNC_W-1:0] s2_r;
    logic [SYNC_W-1:0] s3_r;
    logic [SYNC_W-1:0] q_nxt;

    // a bit moves only once stages two and three agree
    assign q_nxt = (s2_r & s3_r) | (q_o & (s2_r | s3_r));

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_o <= '0;
        end
        else
        begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_o <= q_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/ses_top.sv ====
// module: servo external signal selector with register slave
`timescale 1ns/1ps
`default_nettype none
module ses_top
    import ses_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] lim_mod_i,
    input wire logic [2:0] amp_in_i,
    input wire logic [3:0] dig_in_i,
    input wire logic [3:0] dev_val_i,
    input wire logic fwd_req_i,
    input wire logic rev_req_i,
    output ses_dev_t [3:0] dev_sel_o,
    output logic [3:0] det_o,
    output logic fwd_ok_o,
    output logic rev_ok_o,
    output logic stop_cmd_o,
    output logic home_trig_o,
    output logic chg_trig_o,
    output logic irq_o
);
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } ses_rd_t;

    ses_cfg_t cfg_r [SIG_N];
    logic [12:0] din_base_r;
    logic mode_r;
    logic [3:0] ists_r;
    logic [3:0] mask_r;
    ses_rd_t rd_st_r;
    ses_rd_t rd_st_nxt;

    // ****************************************
    // input synchronisation and selection
    // ****************************************
    logic [SYNC_W-1:0] sync_q;
    logic [31:0] lim_s;
    logic [2:0] amp_s;
    logic [3:0] din_s;
    logic [3:0] det_c;
    logic [3:0] hole;

    ses_sync u_sync (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .d_i({dig_in_i, amp_in_i, lim_mod_i}),
        .q_o(sync_q)
    );

    assign lim_s = sync_q[31:0];
    assign amp_s = sync_q[34:32];
    assign din_s = sync_q[38:35];

    for (genvar g = 0; g < SIG_N; g++)
    begin : g_sig
        // the built-in input block holds only four live bits
        assign hole[g] = (cfg_r[g].dcls == DEV_IN)
                         && (cfg_r[g].dnum[12:4] == din_base_r[12:4])
                         && (cfg_r[g].dnum[3:0] >= DIN_HOLE_LO);
        ses_sel #(.KIND(g)) u_sel (
            .cfg_i(cfg_r[g]),
            .lim_i(lim_s),
            .amp_i(amp_s),
            .din_i(din_s),
            .dev_i(dev_val_i[g] & ~hole[g]),
            .det_o(det_c[g])
        );
    end

    wire [3:0] rise = det_c & ~det_o;

    // ****************************************
    // axis reactions
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            det_o <= 4'h0;
            fwd_ok_o <= 1'b0;
            rev_ok_o <= 1'b0;
            stop_cmd_o <= 1'b0;
            home_trig_o <= 1'b0;
            chg_trig_o <= 1'b0;
            for (int i = 0; i < SIG_N; i++)
            begin
                dev_sel_o[i] <= '0;
            end
        end
        else
        begin
            det_o <= det_c;
            fwd_ok_o <= fwd_req_i & ~det_c[SIG_UPPER];
            rev_ok_o <= rev_req_i & ~det_c[SIG_LOWER];
            stop_cmd_o <= rise[SIG_STOP];
            home_trig_o <= rise[SIG_DOG] & ~mode_r;
            chg_trig_o <= rise[SIG_DOG] & mode_r;
            for (int i = 0; i < SIG_N; i++)
            begin
                dev_sel_o[i] <= {cfg_r[i].dcls, cfg_r[i].dnum};
            end
        end
    end

    // ****************************************
    // write channel
    // ****************************************
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    wire aw_hs = s_axi_awvalid_i & s_axi_awready_o;
    wire w_hs = s_axi_wvalid_i & s_axi_wready_o;
    wire aw_av = aw_have_r | aw_hs;
    wire w_av = w_have_r | w_hs;
    wire do_wr = aw_av & w_av;
    wire [7:0] wa = aw_hs ? s_axi_awaddr_i : waddr_r;
    wire [31:0] wd = w_hs ? s_axi_wdata_i : wdata_r;
    wire [3:0] ws = w_hs ? s_axi_wstrb_i : wstrb_r;
    wire [7:0] wa_w = {wa[7:2], 2'b00};
    wire [1:0] wi = wa[3:2];
    wire wr_cfg = (wa_w <= ADDR_CFG_DOG);
    wire wr_ctrl = (wa_w == ADDR_CTRL);
    wire wr_mask = (wa_w == ADDR_IMASK);
    wire wr_ro = (wa_w == ADDR_DET) || (wa_w == ADDR_ISTAT);
    wire [31:0] cfg_m = ses_merge({5'h0, cfg_r[wi]}, wd, ws);
    wire ses_cfg_t cfg_new = ses_cfg_t'(cfg_m[26:0]);
    wire bad_dev = (cfg_new.typ == SRC_BITDEV) && !ses_dev_ok(cfg_new);
    wire wr_err = !(wr_cfg | wr_ctrl | wr_mask | wr_ro) | (wr_cfg & bad_dev);
    wire [31:0] ctrl_w = {15'h0, mode_r, 3'h0, din_base_r};
    wire [31:0] ctrl_m = ses_merge(ctrl_w, wd, ws);
    wire [31:0] mask_m = ses_merge({28'h0, mask_r}, wd, ws);
    wire bvalid_nxt = do_wr | (s_axi_bvalid_o & ~s_axi_bready_i);

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end
        else
        begin
            aw_have_r <= aw_av & ~do_wr;
            w_have_r <= w_av & ~do_wr;
            waddr_r <= wa;
            wdata_r <= wd;
            wstrb_r <= ws;
            s_axi_awready_o <= ~(aw_av & ~do_wr) & ~bvalid_nxt;
            s_axi_wready_o <= ~(w_av & ~do_wr) & ~bvalid_nxt;
            s_axi_bvalid_o <= bvalid_nxt;
            if (do_wr)
            begin
                s_axi_bresp_o <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // ****************************************
    // configuration and control registers
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < SIG_N; i++)
            begin
                cfg_r[i] <= CFG_RST;
            end
            din_base_r <= DIN_BASE_RST;
            mode_r <= 1'b0;
            mask_r <= MASK_RST;
        end
        else if (do_wr && !wr_err)
        begin
            if (wr_cfg)
            begin
                cfg_r[wi] <= cfg_new;
            end
            if (wr_ctrl)
            begin
                din_base_r <= ctrl_m[12:0];
                mode_r <= ctrl_m[CTRL_MODE_BIT];
            end
            if (wr_mask)
            begin
                mask_r <= mask_m[3:0];
            end
        end
    end

    // ****************************************
    // read channel and interrupt status
    // ****************************************
    wire ar_hs = s_axi_arvalid_i & s_axi_arready_o;
    wire [7:0] ra_w = {s_axi_araddr_i[7:2], 2'b00};
    wire [1:0] ri = s_axi_araddr_i[3:2];
    wire rd_clr = ar_hs && (ra_w == ADDR_ISTAT);
    wire rd_hit = (ra_w <= ADDR_CFG_DOG) || (ra_w == ADDR_CTRL) || (ra_w == ADDR_DET)
                  || (ra_w == ADDR_ISTAT) || (ra_w == ADDR_IMASK);
    wire [31:0] rd_word = (ra_w <= ADDR_CFG_DOG) ? {5'h0, cfg_r[ri]} :
                          (ra_w == ADDR_CTRL) ? ctrl_w :
                          (ra_w == ADDR_DET) ? {28'h0, det_o} :
                          (ra_w == ADDR_ISTAT) ? {28'h0, ists_r} :
                          (ra_w == ADDR_IMASK) ? {28'h0, mask_r} : 32'h0;
    // a new event wins over the clear in the same cycle
    wire [3:0] ists_nxt = (rd_clr ? 4'h0 : ists_r) | rise;

    always_comb
    begin
        case (rd_st_r)
            RD_IDLE: rd_st_nxt = ar_hs ? RD_RESP : RD_IDLE;
            RD_RESP: rd_st_nxt = s_axi_rready_i ? RD_IDLE : RD_RESP;
            default: rd_st_nxt = RD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rd_st_r <= RD_IDLE;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= RESP_OKAY;
            ists_r <= 4'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            rd_st_r <= rd_st_nxt;
            s_axi_arready_o <= (rd_st_nxt == RD_IDLE);
            s_axi_rvalid_o <= (rd_st_nxt == RD_RESP);
            if (ar_hs)
            begin
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            ists_r <= ists_nxt;
            irq_o <= |(ists_nxt & mask_r);
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_none_quiet;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (cfg_r[SIG_UPPER].typ == SRC_NONE) |-> !det_c[SIG_UPPER];
    endproperty
    a_none_quiet: assert property (p_none_quiet) else $error("unused signal detected");

    property p_stop_no_amp;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (cfg_r[SIG_STOP].typ == SRC_AMP) |-> !det_c[SIG_STOP];
    endproperty
    a_stop_no_amp: assert property (p_stop_no_amp) else $error("stop took amp input");

    property p_din_dog_only;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (cfg_r[SIG_UPPER].typ == SRC_DIN) |-> !det_c[SIG_UPPER];
    endproperty
    a_din_dog_only: assert property (p_din_dog_only) else $error("din used off dog");

    property p_upper_block;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (fwd_req_i && det_c[SIG_UPPER]) |=> !fwd_ok_o && det_o[SIG_UPPER];
    endproperty
    a_upper_block: assert property (p_upper_block) else $error("upper limit not held");

    property p_lower_block;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (rev_req_i && !det_c[SIG_LOWER]) ##1 (rev_req_i && det_c[SIG_LOWER])
        |=> !rev_ok_o;
    endproperty
    a_lower_block: assert property (p_lower_block) else $error("lower limit not held");

    property p_stop_pulse;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (det_c[SIG_STOP] && !det_o[SIG_STOP]) |=> stop_cmd_o ##1 !stop_cmd_o;
    endproperty
    a_stop_pulse: assert property (p_stop_pulse) else $error("stop pulse wrong");

    property p_dog_trig;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(det_o[SIG_DOG]) |-> ($past(mode_r) ? chg_trig_o : home_trig_o);
    endproperty
    a_dog_trig: assert property (p_dog_trig) else $error("dog trigger missing");

    property p_bad_dev;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (do_wr && wr_cfg && bad_dev) |=> s_axi_bvalid_o && (s_axi_bresp_o == RESP_SLVERR)
        && $stable(cfg_r[SIG_UPPER]) && $stable(cfg_r[SIG_LOWER])
        && $stable(cfg_r[SIG_STOP]) && $stable(cfg_r[SIG_DOG]);
    endproperty
    a_bad_dev: assert property (p_bad_dev) else $error("bad device accepted");

    property p_hole_zero;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (hole[SIG_DOG] && cfg_r[SIG_DOG].typ == SRC_BITDEV && !cfg_r[SIG_DOG].pol)
        |-> !det_c[SIG_DOG];
    endproperty
    a_hole_zero: assert property (p_hole_zero) else $error("hole bit seen set");
endmodule
`default_nettype wire
